// ==== include/spg_pkg.sv ====
// Package for the shared-pin GPIO port: register map, field layout, pin map and carrier structs.
// Assumes a 16-bit data-space access port and a single system clock.
package spg_pkg;

  // ==================================================
  // Register map (data-space word addresses)
  localparam logic [15:0] ADDR_FUNC_SEL  = 16'h7090;
  localparam logic [15:0] ADDR_PORT_A    = 16'h7098;
  localparam logic [15:0] ADDR_PORT_B    = 16'h709a;

  // ==================================================
  // Field layout and reset values
  localparam int          DATA_LSB       = 0;
  localparam int          DIR_LSB        = 8;
  localparam int          PORT_W         = 8;
  localparam int          PORT_B_BASE    = 8;
  localparam logic [15:0] RST_FUNC_SEL   = 16'h0000;
  localparam logic [15:0] RST_PORT       = 16'h0000;

  // ==================================================
  // Pin map, index = function-select bit
  localparam int          NPIN           = 16;
  // Bonded pins: port A 0..7, port B 0..4
  localparam logic [15:0] PIN_PRESENT    = 16'h1fff;
  // Pins whose primary function drives the pin: A1..A7, B0, B3
  localparam logic [15:0] PRIM_DRIVES    = 16'h09fe;
  // Pins that stay general-purpose whatever the select bit says: B1, B2
  localparam logic [15:0] GPIO_ONLY      = 16'h0600;
  localparam int          PIN_PROTECT    = 0;
  localparam int          PIN_CLOCK_OUTPUT_PIN     = 7;
  localparam int          PIN_TIMER      = 8;
  localparam int          PIN_TX         = 11;
  localparam int          PIN_RX         = 12;

  // ==================================================
  // Carriers
  typedef struct packed {
    logic [5:0] pulse_out;
    logic       clock_output_pin;
    logic       second_timer_pulse_out;
    logic       serial_transmit_pin;
  } spg_prim_t;

  typedef struct packed {
    logic power_drive_protect_input;
    logic serial_receive_pin;
    logic external_irq_one;
    logic external_irq_two;
    logic converter_start_input;
    logic capture_input_one;
  } spg_periph_t;

endpackage

// ==== design/spg_sync.sv ====
// Three-stage input synchroniser with a two-stage agreement filter.
// Assumes inputs are asynchronous to ref_clk.
`timescale 1ns/1ps
module spg_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] level_q
);

  // ==================================================
  // Stages
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // First stage feeds only the second, to keep metastability contained
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          level_q[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule // spg_sync

// ==== design/spg_port.sv ====
// Shared-pin GPIO port: function select, two data/direction ports and the pin multiplexer.
// Assumes the CPU data-space port below and board pins resolved outside from pin_o/pin_oe_n.
//
// How it works
// - Thirteen bonded pins can each act as bidirectional general-purpose I/O, most shared with a peripheral.
// - A select bit of 1 hands the pin to its peripheral, except on B1 and B2, 0 hands it to general-purpose I/O.
// - In I/O function a direction bit of 0 makes the pin an input and 1 drives it as an output.
// - Input pins read back their level through the data bit, output pins drive the written data bit.
// - Direction and data bits are ignored while the peripheral function is selected.
// - The select register is 16 bits, low byte for port A, high byte for port B, reset to all I/O.
// - Port A holds data in bits 0 to 7 and direction in bits 8 to 15, pin n paired with bit n+8.
// - Port B uses the same data and direction layout as port A.
// - The drive-protect input keeps watching port A pin 0 whatever its select bit says.
// - The three registers sit at fixed data-space addresses for ordinary CPU reads and writes.
`timescale 1ns/1ps
module spg_port (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  // CPU data-space access
  input  wire logic [15:0]          bus_addr,
  input  wire logic                 bus_wr,
  input  wire logic                 bus_rd,
  input  wire logic [15:0]          bus_wdata,
  output logic      [15:0]          bus_rdata,
  output logic                      bus_rvalid,
  // Peripheral side
  input  wire spg_pkg::spg_prim_t   prim_i,
  output spg_pkg::spg_periph_t      periph_o,
  // Board pins, index 0..7 port A, 8..15 port B
  input  wire logic [15:0]          pin_i,
  output logic      [15:0]          pin_o,
  output logic      [15:0]          pin_oe_n
);

  // ==================================================
  // Registers
  logic [15:0] func_sel_q;
  logic [15:0] port_a_q;
  logic [15:0] port_b_q;
  logic [15:0] pin_level;
  logic [15:0] prim_val;
  logic [15:0] io_dir;
  logic [15:0] io_dat;
  logic [15:0] is_prim;
  logic [15:0] drive_d;
  logic [15:0] val_d;
  logic [15:0] rd_d;
  logic [7:0]  a_rd;
  logic [7:0]  b_rd;

  // ==================================================
  // Pin input synchroniser
  spg_sync #(
    .W (spg_pkg::NPIN)
  ) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .async_i (pin_i & spg_pkg::PIN_PRESENT),
    .level_q (pin_level)
  );

  // ==================================================
  // Register writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      func_sel_q <= spg_pkg::RST_FUNC_SEL;
    end else if (bus_wr && bus_addr == spg_pkg::ADDR_FUNC_SEL) begin
      func_sel_q <= bus_wdata;
    end
  end

  // Data bits of input pins are stored but never reach the pin
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_a_q <= spg_pkg::RST_PORT;
    end else if (bus_wr && bus_addr == spg_pkg::ADDR_PORT_A) begin
      port_a_q <= bus_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_b_q <= spg_pkg::RST_PORT;
    end else if (bus_wr && bus_addr == spg_pkg::ADDR_PORT_B) begin
      port_b_q <= bus_wdata;
    end
  end

  // ==================================================
  // Per-pin multiplexer
  assign io_dir = {port_b_q[spg_pkg::DIR_LSB +: spg_pkg::PORT_W],
                   port_a_q[spg_pkg::DIR_LSB +: spg_pkg::PORT_W]};
  assign io_dat = {port_b_q[spg_pkg::DATA_LSB +: spg_pkg::PORT_W],
                   port_a_q[spg_pkg::DATA_LSB +: spg_pkg::PORT_W]};
  assign is_prim = func_sel_q & ~spg_pkg::GPIO_ONLY;

  always_comb begin
    prim_val = '0;
    prim_val[6:1] = prim_i.pulse_out;
    prim_val[spg_pkg::PIN_CLOCK_OUTPUT_PIN] = prim_i.clock_output_pin;
    prim_val[spg_pkg::PIN_TIMER] = prim_i.second_timer_pulse_out;
    prim_val[spg_pkg::PIN_TX] = prim_i.serial_transmit_pin;
  end

  genvar i;
  generate
    for (i = 0; i < spg_pkg::NPIN; i++) begin : g_pin
      always_comb begin
        if (!spg_pkg::PIN_PRESENT[i]) begin
          drive_d[i] = 1'b0;
          val_d[i] = 1'b0;
        end else if (is_prim[i]) begin
          // Direction and data ignored in peripheral function
          drive_d[i] = spg_pkg::PRIM_DRIVES[i];
          val_d[i] = prim_val[i];
        end else begin
          drive_d[i] = io_dir[i];
          val_d[i] = io_dat[i];
        end
      end
    end
  endgenerate

  // Pins change one cycle after the register write; enable is active low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_o <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_o <= val_d;
      pin_oe_n <= ~drive_d;
    end
  end

  // ==================================================
  // Peripheral inputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      periph_o <= '0;
    end else begin
      // Protect circuit watches the pin even in I/O function
      periph_o.power_drive_protect_input <= pin_level[spg_pkg::PIN_PROTECT];
      // Receive line idles high when the pin is not given to the serial port
      periph_o.serial_receive_pin <= is_prim[spg_pkg::PIN_RX] ? pin_level[spg_pkg::PIN_RX] : 1'b1;
      periph_o.external_irq_one <= pin_level[spg_pkg::PIN_TIMER];
      periph_o.external_irq_two <= pin_level[spg_pkg::PIN_CLOCK_OUTPUT_PIN];
      periph_o.converter_start_input <= pin_level[spg_pkg::PIN_CLOCK_OUTPUT_PIN];
      periph_o.capture_input_one <= pin_level[spg_pkg::PIN_CLOCK_OUTPUT_PIN];
    end
  end

  // ==================================================
  // Register reads
  always_comb begin
    a_rd = (io_dir[7:0] & io_dat[7:0]) | (~io_dir[7:0] & pin_level[7:0]);
    b_rd = (io_dir[15:8] & io_dat[15:8]) | (~io_dir[15:8] & pin_level[15:8]);
    case (bus_addr)
      spg_pkg::ADDR_FUNC_SEL: rd_d = func_sel_q;
      spg_pkg::ADDR_PORT_A:   rd_d = {io_dir[7:0], a_rd};
      spg_pkg::ADDR_PORT_B:   rd_d = {io_dir[15:8], b_rd};
      default:                rd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= 16'h0000;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_rd;
      if (bus_rd) begin
        bus_rdata <= rd_d;
      end
    end
  end

endmodule // spg_port

// ==== sim/spg_port_props.sv ====
// Checker for spg_port, bound to every instance.
// Assumes the register contents can be shadowed from the writes seen at the ports.
`timescale 1ns/1ps
module spg_port_props (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rstn,
  // Bus
  input wire logic [15:0]          bus_addr,
  input wire logic                 bus_wr,
  input wire logic                 bus_rd,
  input wire logic [15:0]          bus_wdata,
  input wire logic [15:0]          bus_rdata,
  input wire logic                 bus_rvalid,
  // Pins and peripherals
  input wire spg_pkg::spg_prim_t   prim_i,
  input wire spg_pkg::spg_periph_t periph_o,
  input wire logic [15:0]          pin_i,
  input wire logic [15:0]          pin_o,
  input wire logic [15:0]          pin_oe_n
);
  // ====================
  // Shadow registers
  logic [15:0] sel_q, pa_q, pb_q;
  logic        mapped;
  assign mapped = bus_addr inside {spg_pkg::ADDR_FUNC_SEL, spg_pkg::ADDR_PORT_A, spg_pkg::ADDR_PORT_B};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= 16'h0;
      pa_q  <= 16'h0;
      pb_q  <= 16'h0;
    end else if (bus_wr) begin
      if (bus_addr == spg_pkg::ADDR_FUNC_SEL) sel_q <= bus_wdata;
      if (bus_addr == spg_pkg::ADDR_PORT_A) pa_q <= bus_wdata;
      if (bus_addr == spg_pkg::ADDR_PORT_B) pb_q <= bus_wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ====================
  // Properties
  a_rd_answer: assert property (bus_rd |=> bus_rvalid)
    else $error("read not answered");
  a_unbonded_idle: assert property (pin_oe_n[15:13] == 3'h7)
    else $error("unbonded pin driven");
  a_sel_read: assert property (bus_rd && bus_addr == spg_pkg::ADDR_FUNC_SEL |=> bus_rdata == $past(sel_q))
    else $error("select readback wrong");
  a_unmapped_zero: assert property (bus_rd && !mapped |=> bus_rdata == 16'h0)
    else $error("unmapped read not zero");
  a_port_read: assert property (bus_rd && bus_addr == spg_pkg::ADDR_PORT_A |=> bus_rdata[15:8] == $past(pa_q[15:8])
    && ((bus_rdata[7:0] ^ $past(pa_q[7:0])) & $past(pa_q[15:8])) == 8'h0) else $error("port read wrong");
  a_port_b_read: assert property (bus_rd && bus_addr == spg_pkg::ADDR_PORT_B
    |=> bus_rdata[15:8] == $past(pb_q[15:8]) && ((bus_rdata[7:0] ^ $past(pb_q[7:0])) & $past(pb_q[15:8])) == 8'h0)
    else $error("port b read wrong");
  a_prim_pulse: assert property (sel_q[1] |=> !pin_oe_n[1] && pin_o[1] == $past(prim_i.pulse_out[0]))
    else $error("pulse output not routed");
  a_gpio_out: assert property (!sel_q[3] && pa_q[11] |=> !pin_oe_n[3] && pin_o[3] == $past(pa_q[3]))
    else $error("output pin not driven");
  a_gpio_in: assert property (!sel_q[2] && !pa_q[10] |=> pin_oe_n[2])
    else $error("input pin driven");
  a_protect_watch: assert property ($stable(pin_i[0]) [*8] |=> periph_o.power_drive_protect_input == $past(pin_i[0]))
    else $error("protect input not following pin");
  c_sel_write: cover property (bus_wr && bus_addr == spg_pkg::ADDR_FUNC_SEL);
  c_prim_high: cover property (sel_q[1] && prim_i.pulse_out[0]);
  c_port_b_read: cover property (bus_rd && bus_addr == spg_pkg::ADDR_PORT_B);
endmodule // spg_port_props
bind spg_port spg_port_props i_spg_port_props (.ref_clk, .rstn, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
  .bus_rdata, .bus_rvalid, .prim_i, .periph_o, .pin_i, .pin_o, .pin_oe_n);

// ==== sim/spg_board.sv ====
// Board model: resolves each pin from the device drive and the board's own level.
// Assumes the board drives weakly, so the device wins wherever it drives.
`timescale 1ns/1ps
module spg_board (
  // Device side
  input wire logic [15:0] pin_o,
  input wire logic [15:0] pin_oe_n,
  // Board side
  input wire logic [15:0] ext_lvl,
  output logic     [15:0] pin_i
);
  assign pin_i = (pin_o & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule // spg_board

// ==== sim/testbench.sv ====
// Self-checking bench for spg_port with a board model on its pins.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic ref_clk, rstn, bus_wr, bus_rd, bus_rvalid;
  logic [15:0] bus_addr, bus_wdata, bus_rdata, pin_i, pin_o, pin_oe_n, ext_lvl, sel, pa, pb, lv, eo, rv;
  spg_pkg::spg_prim_t   prim_i;
  spg_pkg::spg_periph_t periph_o;
  int failures, checked;
  spg_port i_spg_port (.ref_clk, .rstn, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_rvalid,
    .prim_i, .periph_o, .pin_i, .pin_o, .pin_oe_n);
  spg_board i_spg_board (.pin_o, .pin_oe_n, .ext_lvl, .pin_i);
  // ====================
  // Expectations
  function automatic logic [15:0] exp_oen(input logic [15:0] s, a, b);
    logic [15:0] d;
    d = {b[15:8], a[15:8]};
    for (int k = 0; k < 16; k++) begin
      if (!spg_pkg::PIN_PRESENT[k]) d[k] = 1'b0;
      else if (s[k] && !spg_pkg::GPIO_ONLY[k]) d[k] = spg_pkg::PRIM_DRIVES[k];
    end
    return ~d;
  endfunction
  function automatic logic [15:0] exp_out(input logic [15:0] s, a, b, input logic [8:0] p);
    logic [15:0] o, pv;
    o = {b[7:0], a[7:0]};
    pv = {4'h0, p[0], 2'h0, p[1], p[2], p[8:3], 1'b0};
    for (int k = 0; k < 16; k++) begin
      if (s[k] && !spg_pkg::GPIO_ONLY[k]) o[k] = pv[k];
    end
    return o;
  endfunction
  // ====================
  // Bus tasks
  task automatic wr(input logic [15:0] a, d);
    @(posedge ref_clk); #2;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge ref_clk); #2;
    bus_wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge ref_clk); #2;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge ref_clk); #2;
    bus_rd = 1'b0;
    `CHK(bus_rvalid, 1'b1)
    d = bus_rdata;
  endtask
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ====================
  // Clock, watchdog, tests
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    failures++;
    end_sim();
  end
  initial begin
    rstn = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 16'h0;
    bus_wdata = 16'h0;
    ext_lvl = 16'h0;
    prim_i = '0;
    void'($urandom(32'hb86b));
    repeat (4) @(posedge ref_clk);
    #2 rstn = 1'b1;
    `CHK(pin_oe_n, 16'hffff)
    // Unmapped write must leave every register at its reset value
    wr(16'h7092, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      rd(i == 0 ? spg_pkg::ADDR_FUNC_SEL : i == 1 ? spg_pkg::ADDR_PORT_A : i == 2 ? spg_pkg::ADDR_PORT_B : 16'h7092, rv);
      `CHK(rv, 16'h0)
    end
    for (int i = 0; i < 40; i++) begin
      sel = i == 0 ? 16'hffff : i == 1 ? 16'h0 : 16'($urandom);
      pa = i < 2 ? 16'hff55 : 16'($urandom);
      pb = i < 2 ? 16'hffaa : 16'($urandom);
      ext_lvl = 16'($urandom);
      prim_i = spg_pkg::spg_prim_t'(9'($urandom));
      wr(spg_pkg::ADDR_FUNC_SEL, sel);
      wr(spg_pkg::ADDR_PORT_A, pa);
      wr(spg_pkg::ADDR_PORT_B, pb);
      repeat (10) @(posedge ref_clk);
      #2;
      eo = exp_oen(sel, pa, pb);
      lv = (exp_out(sel, pa, pb, prim_i) & ~eo) | (ext_lvl & eo);
      `CHK(pin_oe_n, eo)
      `CHK(pin_o & ~eo, exp_out(sel, pa, pb, prim_i) & ~eo)
      `CHK(periph_o, {lv[0], sel[12] ? lv[12] : 1'b1, lv[8], {3{lv[7]}}})
      rd(spg_pkg::ADDR_PORT_A, rv);
      `CHK(rv, {pa[15:8], (pa[7:0] & pa[15:8]) | (lv[7:0] & ~pa[15:8])})
      rd(spg_pkg::ADDR_PORT_B, rv);
      `CHK(rv, {pb[15:8], (pb[7:0] & pb[15:8]) | (lv[15:8] & spg_pkg::PIN_PRESENT[15:8] & ~pb[15:8])})
      rd(spg_pkg::ADDR_FUNC_SEL, rv);
      `CHK(rv, sel)
    end
    end_sim();
  end
endmodule // testbench
